// ==== rtl/gcfc_top.sv ====
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps

// Overview of operation
// [R1] Enable bit turns display module on.
// [R2] Idle-halt bit stops module during Idle.
// [R3] Watermark N flags fall N to N-1.
// [R4] Watermark zero never raises level flag.
// [R5] Pixel depth codes select 1..16 bpp.
// [R6] Read-only count reports queued commands 0..16.
// [R7] Full queue drops further commands.
// [R8] Bit 14 reads zero, ignores writes.
// [R9] Upper word/high-byte write pushes command.
// [R10] Lower half writes store only, never push.
// [R11] Count up on push, down on pop.
module gcfc_top #(
    parameter int DEPTH = gcfc_pkg::GCFC_QUEUE_DEPTH,
    parameter int WIDTH = gcfc_pkg::GCFC_CMD_WIDTH
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [1:0] byte_en_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic system_idle_in,
    input wire logic gpu_take_in,
    output logic gpu_cmd_valid_out,
    output logic [WIDTH-1:0] gpu_cmd_out,
    output logic module_run_out,
    output logic [2:0] pixel_depth_out,
    output logic depth_reserved_out,
    output logic irq_out
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    localparam int AW = $clog2(DEPTH);

    gcfc_pkg::gcfc_bus_req_t req;
    gcfc_pkg::gcfc_ctrl_t ctrl_ff;
    logic [15:0] cmd_lower_ff;
    logic [15:0] cmd_upper_ff;
    logic [4:0] count_ff;
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic idle_sync1_ff;
    logic idle_sync2_ff;
    logic [WIDTH-1:0] mem_rd_data;

    assign req = '{addr: addr_in, wdata: wdata_in, byte_en: byte_en_in, wr: wr_in, rd: rd_in};

    wire wr_lower = req.wr && (req.addr == gcfc_pkg::GCFC_ADDR_CMD_LOWER);
    wire wr_upper = req.wr && (req.addr == gcfc_pkg::GCFC_ADDR_CMD_UPPER);
    wire wr_ctrl = req.wr && (req.addr == gcfc_pkg::GCFC_ADDR_CONTROL_ONE);
    wire wr_status = req.wr && (req.addr == gcfc_pkg::GCFC_ADDR_IRQ_STATUS);
    wire wr_mask = req.wr && (req.addr == gcfc_pkg::GCFC_ADDR_IRQ_MASK);

    // Byte lane merge: a register keeps lanes whose enable is low.
    function automatic logic [15:0] merge_lanes(input logic [15:0] old_v, input logic [15:0] new_v,
                                                input logic [1:0] be);
        merge_lanes = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // ****************************************************************
    // Queue control
    // ****************************************************************
    wire queue_full = (count_ff == 5'(DEPTH));
    wire queue_empty = (count_ff == gcfc_pkg::GCFC_RESET_COUNT);
    // The push uses the freshly written upper bytes so a word write carries its own data.
    wire push_req = wr_upper && req.byte_en[1]; // R9
    wire push_ok = push_req && !queue_full; // R7
    wire push_drop = push_req && queue_full; // R7
    wire [15:0] nxt_cmd_upper = merge_lanes(cmd_upper_ff, req.wdata, req.byte_en);
    wire [WIDTH-1:0] push_word = WIDTH'({nxt_cmd_upper, cmd_lower_ff});
    // Halting in Idle freezes the consumer side; software may still fill the queue.
    wire halted = idle_sync2_ff && ctrl_ff.idle_halt; // R2
    wire running = ctrl_ff.module_on && !halted; // R1
    // The head word leaves only when the consumer takes it while it is shown valid.
    wire pop_ok = gpu_take_in && gpu_cmd_valid_out && running && !queue_empty; // R11
    wire [4:0] nxt_count = count_ff + 5'(push_ok) - 5'(pop_ok); // R6 R11
    wire level_hit = pop_ok && (ctrl_ff.watermark != 5'h00) && (count_ff == ctrl_ff.watermark); // R3 R4

    gcfc_queue_mem #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .clk_in(clk_in),
        .wr_en_in(push_ok),
        .wr_addr_in(wr_ptr_ff),
        .wr_data_in(push_word),
        .rd_addr_in(pop_ok ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff),
        .rd_data_out(mem_rd_data)
    );

    // ****************************************************************
    // Idle synchroniser
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            idle_sync1_ff <= 1'b0;
            idle_sync2_ff <= 1'b0;
        end else begin
            idle_sync1_ff <= system_idle_in;
            idle_sync2_ff <= idle_sync1_ff;
        end
    end

    // ****************************************************************
    // Command halves and control register
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cmd_lower_ff <= gcfc_pkg::GCFC_RESET_WORD;
            cmd_upper_ff <= gcfc_pkg::GCFC_RESET_WORD;
            ctrl_ff <= '0;
        end else begin
            if (wr_lower) begin
                cmd_lower_ff <= merge_lanes(cmd_lower_ff, req.wdata, req.byte_en); // R10
            end
            if (wr_upper) begin
                cmd_upper_ff <= nxt_cmd_upper; // R9
            end
            if (wr_ctrl && req.byte_en[1]) begin
                ctrl_ff.module_on <= req.wdata[gcfc_pkg::GCFC_POS_MODULE_ON]; // R1
                ctrl_ff.idle_halt <= req.wdata[gcfc_pkg::GCFC_POS_IDLE_HALT]; // R2
                ctrl_ff.watermark <= req.wdata[gcfc_pkg::GCFC_POS_WMK_LSB +: 5]; // R3
            end
            if (wr_ctrl && req.byte_en[0]) begin
                ctrl_ff.pixel_depth <= req.wdata[gcfc_pkg::GCFC_POS_DEPTH_LSB +: 3]; // R5
            end
        end
    end

    // ****************************************************************
    // Queue pointers and occupancy
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            count_ff <= gcfc_pkg::GCFC_RESET_COUNT;
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            count_ff <= nxt_count; // R6
            if (push_ok) begin
                wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            end
            if (pop_ok) begin
                rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
            end
        end
    end

    // ****************************************************************
    // Consumer side
    // ****************************************************************
    // Valid waits one cycle after a push into an empty queue so the registered
    // memory read has caught up with the new head word.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            gpu_cmd_valid_out <= 1'b0;
            module_run_out <= 1'b0;
            pixel_depth_out <= 3'h0;
            depth_reserved_out <= 1'b0;
        end else begin
            gpu_cmd_valid_out <= running && (nxt_count != gcfc_pkg::GCFC_RESET_COUNT) && !pop_ok &&
                                 !(push_ok && queue_empty);
            module_run_out <= running; // R1 R2
            pixel_depth_out <= ctrl_ff.pixel_depth; // R5
            depth_reserved_out <= ctrl_ff.pixel_depth > gcfc_pkg::GCFC_DEPTH_MAX_CODE; // R5
        end
    end

    assign gpu_cmd_out = mem_rd_data;

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    wire [1:0] irq_events = {push_drop, level_hit};
    wire [1:0] irq_clear = wr_status ? req.wdata[1:0] & {2{req.byte_en[0]}} : 2'b00;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            irq_status_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
            irq_out <= 1'b0;
        end else begin
            // A new event in the clearing cycle keeps its bit set.
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events; // R3
            if (wr_mask && req.byte_en[0]) begin
                irq_mask_ff <= req.wdata[1:0];
            end
            irq_out <= |(((irq_status_ff & ~irq_clear) | irq_events) & irq_mask_ff);
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire [15:0] ctrl_word = {ctrl_ff.module_on, 1'b0, ctrl_ff.idle_halt, ctrl_ff.watermark,
                             ctrl_ff.pixel_depth, count_ff}; // R8 R6
    logic [15:0] read_mux;

    always_comb begin
        unique case (req.addr)
            gcfc_pkg::GCFC_ADDR_CMD_LOWER: read_mux = cmd_lower_ff;
            gcfc_pkg::GCFC_ADDR_CMD_UPPER: read_mux = cmd_upper_ff;
            gcfc_pkg::GCFC_ADDR_CONTROL_ONE: read_mux = ctrl_word;
            gcfc_pkg::GCFC_ADDR_IRQ_STATUS: read_mux = {14'h0000, irq_status_ff};
            gcfc_pkg::GCFC_ADDR_IRQ_MASK: read_mux = {14'h0000, irq_mask_ff};
            default: read_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= req.rd ? read_mux : 16'h0000;
        end
    end

endmodule // gcfc_top

// ==== rtl/gcfc_pkg.sv ====
package gcfc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] GCFC_ADDR_CMD_LOWER = 4'h0;
    localparam logic [3:0] GCFC_ADDR_CMD_UPPER = 4'h1;
    localparam logic [3:0] GCFC_ADDR_CONTROL_ONE = 4'h2;
    localparam logic [3:0] GCFC_ADDR_IRQ_STATUS = 4'h3;
    localparam logic [3:0] GCFC_ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] GCFC_ADDR_POP_DATA_LOW = 4'h5;
    localparam logic [3:0] GCFC_ADDR_POP_DATA_HIGH = 4'h6;

    // ****************************************************************
    // Field positions of display_control_one
    // ****************************************************************
    localparam int GCFC_POS_MODULE_ON = 15;
    localparam int GCFC_POS_UNUSED = 14;
    localparam int GCFC_POS_IDLE_HALT = 13;
    localparam int GCFC_POS_WMK_LSB = 8;
    localparam int GCFC_POS_DEPTH_LSB = 5;
    localparam int GCFC_POS_COUNT_LSB = 0;

    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int GCFC_QUEUE_DEPTH = 16;
    localparam int GCFC_CMD_WIDTH = 32;
    localparam logic [15:0] GCFC_RESET_WORD = 16'h0000;
    localparam logic [4:0] GCFC_RESET_COUNT = 5'h00;
    localparam logic [2:0] GCFC_DEPTH_MAX_CODE = 3'h4;
    localparam int GCFC_IRQ_BIT_LEVEL = 0;
    localparam int GCFC_IRQ_BIT_DROP = 1;

    // ****************************************************************
    // Bus carrier
    // ****************************************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic [1:0] byte_en;
        logic wr;
        logic rd;
    } gcfc_bus_req_t;

    typedef struct packed {
        logic module_on;
        logic idle_halt;
        logic [4:0] watermark;
        logic [2:0] pixel_depth;
    } gcfc_ctrl_t;

endpackage

// ==== rtl/gcfc_queue_mem.sv ====
`timescale 1ns/10ps

// Small register-file memory holding queued commands; read data are registered.
module gcfc_queue_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);

    logic [WIDTH-1:0] mem_ff [DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_ff[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_ff[rd_addr_in];
    end

endmodule // gcfc_queue_mem

// ==== tb/gcfc_chk.sv ====
`timescale 1ns/10ps

// ****************************************************************
// Port watchers for the command queue control block
// ****************************************************************
module gcfc_chk #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [1:0] byte_en_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic gpu_take_in,
    input wire logic gpu_cmd_valid_out,
    input wire logic [WIDTH-1:0] gpu_cmd_out,
    input wire logic module_run_out,
    input wire logic [2:0] pixel_depth_out,
    input wire logic depth_reserved_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic rd_ctl = rd_in && addr_in == gcfc_pkg::GCFC_ADDR_CONTROL_ONE;
    wire logic wr_ctl = wr_in && addr_in == gcfc_pkg::GCFC_ADDR_CONTROL_ONE && byte_en_in[1];

    property p_gap;
        !rd_in |=> rdata_out == 16'h0000;
    endproperty
    a_gap: assert property (p_gap) else $error("read data not zero outside a read");
    property p_bit14;
        rd_ctl |=> !rdata_out[gcfc_pkg::GCFC_POS_UNUSED];
    endproperty
    a_bit14: assert property (p_bit14) else $error("unused control bit reads one");
    property p_count_max;
        rd_ctl |=> rdata_out[4:0] <= DEPTH;
    endproperty
    a_count_max: assert property (p_count_max) else $error("occupancy above queue depth");
    property p_off;
        wr_ctl && !wdata_in[gcfc_pkg::GCFC_POS_MODULE_ON] |-> ##2 !module_run_out;
    endproperty
    a_off: assert property (p_off) else $error("module still runs after disable");
    property p_depth;
        depth_reserved_out == (pixel_depth_out > gcfc_pkg::GCFC_DEPTH_MAX_CODE);
    endproperty
    a_depth: assert property (p_depth) else $error("reserved depth flag wrong");
    property p_pop;
        gpu_take_in && gpu_cmd_valid_out && module_run_out |=> !gpu_cmd_valid_out;
    endproperty
    a_pop: assert property (p_pop) else $error("valid kept after a take");
    property p_fall;
        $fell(gpu_cmd_valid_out) |-> $past(gpu_take_in) || !module_run_out || !$past(module_run_out);
    endproperty
    a_fall: assert property (p_fall) else $error("valid dropped without a take");
    property p_hold;
        gpu_cmd_valid_out && $past(gpu_cmd_valid_out) |-> $stable(gpu_cmd_out);
    endproperty
    a_hold: assert property (p_hold) else $error("head command changed while valid");
    property p_irq;
        $rose(irq_out) |-> $past(gpu_take_in) || $past(gpu_take_in, 2) || $past(wr_in) || $past(wr_in, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt rose without a cause");
endmodule // gcfc_chk

bind gcfc_top gcfc_chk #(.DEPTH(DEPTH), .WIDTH(WIDTH)) i_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .byte_en_in(byte_en_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .gpu_take_in(gpu_take_in), .gpu_cmd_valid_out(gpu_cmd_valid_out),
    .gpu_cmd_out(gpu_cmd_out), .module_run_out(module_run_out), .pixel_depth_out(pixel_depth_out),
    .depth_reserved_out(depth_reserved_out), .irq_out(irq_out));

// ==== tb/gpu_command_fifo_control_tb_top.sv ====
`timescale 1ns/10ps

module gpu_command_fifo_control_tb_top;
    localparam logic [3:0] ctl = gcfc_pkg::GCFC_ADDR_CONTROL_ONE;
    localparam logic [3:0] sts = gcfc_pkg::GCFC_ADDR_IRQ_STATUS;
    localparam logic [3:0] msk = gcfc_pkg::GCFC_ADDR_IRQ_MASK;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic [1:0] byte_en_in = 2'b00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic system_idle_in = 1'b0;
    logic gpu_take_in = 1'b0;
    logic [15:0] rdata_out;
    logic [31:0] gpu_cmd_out;
    logic [2:0] pixel_depth_out;
    logic gpu_cmd_valid_out, module_run_out, depth_reserved_out, irq_out;
    logic [31:0] exp_q[$];
    logic [15:0] lo;
    int n_fail = 0;
    int checks = 0;

    always #50 clk_in = ~clk_in;

    gcfc_top i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .byte_en_in(byte_en_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .system_idle_in(system_idle_in), .gpu_take_in(gpu_take_in), .gpu_cmd_valid_out(gpu_cmd_valid_out),
        .gpu_cmd_out(gpu_cmd_out), .module_run_out(module_run_out), .pixel_depth_out(pixel_depth_out),
        .depth_reserved_out(depth_reserved_out), .irq_out(irq_out));

    // ****************************************************************
    // Bus and consumer tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        byte_en_in <= be;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask

    // The idle input passes a two-flop synchroniser, so the wait covers its lag.
    task automatic mode(input logic [15:0] cw, input logic idle, input logic run);
        wr(ctl, cw, 2'b11);
        system_idle_in <= idle;
        repeat (6) @(posedge clk_in);
        #1;
        chk(module_run_out, run);
    endtask

    task automatic pop(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge clk_in);
                #1;
                k++;
            end while (gpu_cmd_valid_out !== 1'b1 && k < 50);
            chk(gpu_cmd_out, exp_q.pop_front());
            @(posedge clk_in);
            gpu_take_in <= 1'b1;
            @(posedge clk_in);
            gpu_take_in <= 1'b0;
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        conclude();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(ctl, 16'h0000);
        wr(4'hF, 16'hFFFF, 2'b11);
        rd(4'hF, 16'h0000);
        wr(ctl, 16'hFFFF, 2'b11);
        rd(ctl, 16'hBFE0);
        for (int c = 0; c < 8; c++) begin
            wr(ctl, {8'h00, c[2:0], 5'h00}, 2'b11);
            repeat (2) @(posedge clk_in);
            #1;
            chk({depth_reserved_out, pixel_depth_out}, {c > 4, c[2:0]});
        end
        $display("test registers done");
        mode(16'h8000, 1'b0, 1'b1);
        mode(16'hA000, 1'b1, 1'b0);
        mode(16'hA000, 1'b0, 1'b1);
        mode(16'h8000, 1'b1, 1'b1);
        mode(16'h0000, 1'b0, 1'b0);
        $display("test mode done");
        wr(ctl, 16'h1000, 2'b11);
        wr(msk, 16'h0003, 2'b11);
        for (int i = 0; i < 17; i++) begin
            lo = 16'(i) * 16'h1111;
            wr(gcfc_pkg::GCFC_ADDR_CMD_LOWER, lo, 2'b11);
            if (i == 0) begin
                wr(gcfc_pkg::GCFC_ADDR_CMD_UPPER, ~lo, 2'b01);
                rd(ctl, 16'h1000);
                wr(gcfc_pkg::GCFC_ADDR_CMD_UPPER, ~lo, 2'b10);
            end else begin
                wr(gcfc_pkg::GCFC_ADDR_CMD_UPPER, ~lo, 2'b11);
            end
            if (i < 16) begin
                exp_q.push_back({~lo, lo});
            end
        end
        rd(ctl, 16'h1010);
        rd(sts, 16'h0002);
        chk(irq_out, 1'b1);
        wr(sts, 16'h0002, 2'b11);
        rd(sts, 16'h0000);
        chk(irq_out, 1'b0);
        $display("test fill done");
        wr(ctl, 16'h9000, 2'b11);
        pop(1);
        rd(sts, 16'h0001);
        chk(irq_out, 1'b1);
        wr(msk, 16'h0000, 2'b11);
        rd(sts, 16'h0001);
        chk(irq_out, 1'b0);
        wr(sts, 16'h0001, 2'b11);
        wr(msk, 16'h0003, 2'b11);
        wr(ctl, 16'h8000, 2'b11);
        pop(14);
        rd(sts, 16'h0000);
        chk(irq_out, 1'b0);
        wr(ctl, 16'h8100, 2'b11);
        pop(1);
        rd(sts, 16'h0001);
        rd(ctl, 16'h8100);
        chk(irq_out, 1'b1);
        $display("test drain done");
        conclude();
    end
endmodule // gpu_command_fifo_control_tb_top
